//--- bench/pilc_regs_tb.sv
// Self-checking bench for the register slice: registers, interrupt path, LEDs, soft reset.
// Assumes the design package and the station management model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); end end

module pilc_regs_tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, autoneg = 1'b0, enh = 1'b0;
  logic [7:0] wb_adr, ev = 8'h00, enh_led = 8'h00;
  logic [3:0] wb_sel, advert = 4'h7;
  logic [31:0] wb_wdat, wb_rdat;
  logic irq, neg_dis, loopback, led_act, led_gig, led_fast;
  logic [2:0] edge_rate, pins = 3'h0, cable = 3'h5;
  logic [15:0] rd;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int hi;

  always #10 i_clock = ~i_clock;

  pilc_sm_model SM (.i_clock(i_clock), .i_wb_ack(wb_ack), .i_wb_dat(wb_rdat),
    .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb), .o_wb_we(wb_we), .o_wb_adr(wb_adr),
    .o_wb_sel(wb_sel), .o_wb_dat(wb_wdat));

  pilc_regs DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
    .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
    .i_ev_speed(ev[7]), .i_ev_link(ev[6]), .i_ev_duplex(ev[5]), .i_ev_neg_err(ev[4]),
    .i_ev_neg_done(ev[3]), .i_ev_powered(ev[2]), .i_ev_downshift(ev[1]), .i_ev_ms_err(ev[0]),
    .i_autoneg_en(autoneg), .i_advert_bits(advert), .i_cable_len(cable),
    .i_enhanced_led(enh), .i_enh_led(enh_led), .i_link_fast(pins[2]), .i_link_gig(pins[1]),
    .i_activity(pins[0]), .o_management_irq_out(irq), .o_negotiation_disabled(neg_dis),
    .o_edge_rate(edge_rate), .o_conn_loopback(loopback), .o_activity_light_pin(led_act),
    .o_gigabit_link_light_pin(led_gig), .o_fast_link_light_pin(led_fast));

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] unused;
    SM.xfer(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    SM.xfer(1'b0, a, 16'h0000, rd);
    `CHK(rd, exp, "read back")
  endtask

  task automatic pulse_ev(input logic [7:0] m);
    @(posedge i_clock);
    ev <= m;
    @(posedge i_clock);
    ev <= 8'h00;
    @(posedge i_clock);
  endtask

  task automatic t_reset_and_ctl2;
    rd_chk(pilc_pkg::IDX_EXT_CTL2, 16'hc00a);
    rd_chk(pilc_pkg::IDX_IRQ_MASK, 16'h0000);
    rd_chk(pilc_pkg::IDX_LED_CTL, 16'h0000);
    rd_chk(8'h05, 16'h0000);
    wr(pilc_pkg::IDX_EXT_CTL2, 16'hffff);
    rd_chk(pilc_pkg::IDX_EXT_CTL2, 16'he00b);
    `CHK(loopback, 1'b1, "loopback")
    wr(pilc_pkg::IDX_EXT_CTL2, 16'h6000);
    `CHK(edge_rate, 3'b011, "slowest edge")
    wr(pilc_pkg::IDX_EXT_CTL2, 16'h8000);
    `CHK(edge_rate, 3'b100, "fastest edge")
    cable <= 3'h7;
    rd_chk(pilc_pkg::IDX_EXT_CTL2, 16'h800e);
    $display("test ctl2 done");
  endtask

  task automatic t_interrupts;
    wr(pilc_pkg::IDX_IRQ_MASK, 16'hffff);
    rd_chk(pilc_pkg::IDX_IRQ_MASK, 16'hfe06);
    pulse_ev(8'ha2);
    `CHK(irq, 1'b0, "unqualified events")
    `CHK(neg_dis, 1'b1, "negotiation off flag")
    @(posedge i_clock);
    autoneg <= 1'b1;
    pulse_ev(8'he2);
    `CHK(irq, 1'b1, "pin follows pending")
    `CHK(neg_dis, 1'b0, "negotiation on flag")
    rd_chk(pilc_pkg::IDX_IRQ_FLAGS, 16'hf000);
    rd_chk(pilc_pkg::IDX_IRQ_FLAGS, 16'h0000);
    `CHK(irq, 1'b0, "pin after clear")
    advert <= 4'hf;
    pulse_ev(8'h1f);
    rd_chk(pilc_pkg::IDX_IRQ_FLAGS, 16'h8e06);
    wr(pilc_pkg::IDX_IRQ_MASK, 16'h7e06);
    pulse_ev(8'h40);
    `CHK(irq, 1'b0, "pin gated")
    rd_chk(pilc_pkg::IDX_IRQ_FLAGS, 16'ha000);
    $display("test interrupts done");
  endtask

  task automatic t_leds;
    wr(pilc_pkg::IDX_LED_CTL, 16'hffff);
    rd_chk(pilc_pkg::IDX_LED_CTL, 16'h3cce);
    repeat (8) @(posedge i_clock);
    `CHK({led_fast, led_gig, led_act}, 3'b000, "disable wins")
    wr(pilc_pkg::IDX_LED_CTL, 16'h2880);
    repeat (8) @(posedge i_clock);
    `CHK({led_fast, led_gig, led_act}, 3'b111, "forced on")
    enh <= 1'b1;
    enh_led <= 8'h05;
    repeat (8) @(posedge i_clock);
    `CHK({led_fast, led_gig, led_act}, 3'b101, "enhanced method")
    enh <= 1'b0;
    pins <= 3'b111;
    wr(pilc_pkg::IDX_LED_CTL, 16'h0000);
    repeat (8) @(posedge i_clock);
    `CHK({led_fast, led_gig, led_act}, 3'b111, "live link state")
    pins <= 3'b000;
    wr(pilc_pkg::IDX_LED_CTL, 16'h0088);
    repeat (8) @(posedge i_clock);
    hi = 0;
    repeat (pilc_pkg::PULSE_CYCLES) begin
      @(posedge i_clock);
      hi += int'(led_act === 1'b1);
    end
    `CHK(hi, pilc_pkg::PULSE_ON_CYCLES, "pulse duty")
    $display("test leds done");
  endtask

  task automatic t_soft_reset;
    wr(pilc_pkg::IDX_IRQ_MASK, 16'hfe06);
    wr(pilc_pkg::IDX_RESET_CTL, 16'h0003);
    rd_chk(pilc_pkg::IDX_IRQ_MASK, 16'hf606);
    rd_chk(pilc_pkg::IDX_LED_CTL, 16'h0088);
    wr(pilc_pkg::IDX_RESET_CTL, 16'h0001);
    rd_chk(pilc_pkg::IDX_IRQ_MASK, 16'h0000);
    rd_chk(pilc_pkg::IDX_EXT_CTL2, 16'hc00e);
    rd_chk(pilc_pkg::IDX_LED_CTL, 16'h0000);
    $display("test soft reset done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 10k cycles; the ceiling leaves ample margin
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset_and_ctl2();
    t_interrupts();
    t_leds();
    t_soft_reset();
    conclude();
  end
endmodule // pilc_regs_tb

`default_nettype wire

//--- bench/pilc_sm_model.sv
// Station management controller model: classic Wishbone master for the register slice.
// Assumes a slave that answers with a registered one-cycle ack; waits are cut by the bench.
`timescale 1ns/1ps
`default_nettype none

module pilc_sm_model (
  input wire logic i_clock, // Core clock
  input wire logic i_wb_ack, // Slave acknowledge
  input wire logic [31:0] i_wb_dat, // Slave read data
  output logic o_wb_cyc, // Cycle
  output logic o_wb_stb, // Strobe
  output logic o_wb_we, // Write enable
  output logic [7:0] o_wb_adr, // Register index
  output logic [3:0] o_wb_sel, // Byte selects
  output logic [31:0] o_wb_dat // Write data
);
  initial begin
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we = 1'b0;
    o_wb_adr = 8'h00;
    o_wb_sel = 4'h0;
    o_wb_dat = 32'h0000_0000;
  end

  // Values seen right after the edge are the ones sampled at it, since the slave uses NBAs
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(posedge i_clock);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we <= we;
    o_wb_adr <= adr;
    o_wb_sel <= 4'h3;
    o_wb_dat <= {16'h0000, wd};
    do @(posedge i_clock); while (i_wb_ack !== 1'b1);
    rd = i_wb_dat[15:0];
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    o_wb_we <= 1'b0;
    // Let the ack-edge write settle before the caller looks at outputs
    @(posedge i_clock);
  endtask
endmodule // pilc_sm_model

`default_nettype wire

//--- design/pilc_regs.sv
// Management register slice: edge rate, cable length, interrupt mask/status, simple LEDs.
// Assumes a classic Wishbone master, synchronous event pulses and pin-level strap inputs.
// Function
// - Bits 15:13 select 100 Mb edge rate, sticky
// - Bits 3:1 report cable length range
// - Mask bit 15 gates interrupt pin
// - Enabled pin follows summary pending bit
// - Pin gating never stops event latching
// - One mask bit per event, default zero
// - Mask bits sticky except negotiation error
// - Status bits mirror mask positions, rest zero
// - Reading status clears bits set then
// - Status bit 15 summarises pending causes
// - Speed/duplex interrupts need negotiation enable
// - Negotiation-disabled flag is inverse of enable
// - Downshift interrupt needs advertise bits 8:5
// - Indicator_light_control applies only in simple method
// - Bit 13 forces, 12 disables fast LED
// - Bit 11 forces, 10 disables gigabit LED
// - Bit 7 forces, 6 disables activity LED
// - Bit 3 pulses active LEDs 5 kHz 20%
// - Bit 2 blinks activity, bit 1 rate
// - Sticky bits survive soft reset if enabled
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pilc_regs (
  input wire logic i_clock, // Core clock, 50 MHz
  input wire logic i_rst_n, // Hardware reset, async, active low
  input wire logic i_clk_en, // Freezes all state while low
  input wire logic i_wb_cyc, // Wishbone cycle
  input wire logic i_wb_stb, // Wishbone strobe
  input wire logic i_wb_we, // Wishbone write
  input wire logic [7:0] i_wb_adr, // Word index
  input wire logic [3:0] i_wb_sel, // Byte selects
  input wire logic [31:0] i_wb_dat, // Write data
  output logic [31:0] o_wb_dat, // Read data, registered
  output logic o_wb_ack, // Acknowledge pulse
  input wire logic i_ev_speed, // Speed change event pulse
  input wire logic i_ev_link, // Link change event pulse
  input wire logic i_ev_duplex, // Duplex change event pulse
  input wire logic i_ev_neg_err, // Negotiation error event pulse
  input wire logic i_ev_neg_done, // Negotiation complete event pulse
  input wire logic i_ev_powered, // Powered device detect event pulse
  input wire logic i_ev_downshift, // Speed downshift event pulse
  input wire logic i_ev_ms_err, // Master/slave error event pulse
  input wire logic i_autoneg_en, // Control bit 0.12
  input wire logic [3:0] i_advert_bits, // Control bits 4.8:5
  input wire logic [2:0] i_cable_len, // Cable length estimate
  input wire logic i_enhanced_led, // Enhanced LED method selected
  input wire logic [7:0] i_enh_led, // Enhanced LED levels {fast,gig,act}
  input wire logic i_link_fast, // 100 Mb link up, external pin
  input wire logic i_link_gig, // 1000 Mb link up, external pin
  input wire logic i_activity, // Activity, external pin
  output logic o_management_irq_out, // Interrupt pin level, active high
  output logic o_negotiation_disabled, // Inverse of negotiation enable
  output logic [2:0] o_edge_rate, // Transmit edge rate code
  output logic o_conn_loopback, // Connector loopback enable
  output logic o_activity_light_pin, // Activity LED, active high
  output logic o_gigabit_link_light_pin, // 1000 Mb link LED
  output logic o_fast_link_light_pin // 100 Mb link LED
);

  logic [15:0] ext_ctl2;
  logic [15:0] irq_mask;
  logic [15:0] irq_flags;
  logic [15:0] led_ctl;
  logic sticky_en;
  logic soft_rst;
  logic [15:0] next_flags;
  logic [15:0] events;
  logic [15:0] rd_val;
  logic [15:0] wmask16;
  logic req;
  logic wr;
  logic rd_flags;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic link_fast;
  logic link_gig;
  logic activity;
  logic [13:0] pulse_cnt;
  logic [22:0] blink_cnt;
  logic blink_phase;
  logic pulse_on;

  // Merge masked write data into the low halfword
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wrbits,
                                        input logic [15:0] data, input logic [15:0] lanes);
    logic [15:0] m;
    m = wrbits & lanes;
    merge = (old & ~m) | (data & m);
  endfunction

  assign wmask16 = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // Writes commit at the edge where the master samples ack, never earlier
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign rd_flags = req && !i_wb_we && (i_wb_adr == pilc_pkg::IDX_IRQ_FLAGS);

  // Wishbone: one wait state, ack drops the cycle after it is given
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        o_wb_dat <= {16'h0000, rd_val};
      end
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    unique case (i_wb_adr)
      pilc_pkg::IDX_EXT_CTL2: rd_val = ext_ctl2;
      pilc_pkg::IDX_IRQ_MASK: rd_val = irq_mask;
      pilc_pkg::IDX_IRQ_FLAGS: rd_val = irq_flags;
      pilc_pkg::IDX_LED_CTL: rd_val = led_ctl;
      pilc_pkg::IDX_RESET_CTL: rd_val = {14'h0000, sticky_en, 1'b0};
      default: rd_val = 16'h0000;
    endcase
  end

  // Software reset is a one-cycle pulse from a write of the reset control register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_rst <= 1'b0;
      sticky_en <= pilc_pkg::RST_STICKY_EN_DEFAULT;
    end else if (i_clk_en) begin
      soft_rst <= wr && i_wb_sel[0] && (i_wb_adr == pilc_pkg::IDX_RESET_CTL)
                  && i_wb_dat[pilc_pkg::RST_CTL_SWRST];
      if (wr && i_wb_sel[0] && i_wb_adr == pilc_pkg::IDX_RESET_CTL) begin
        sticky_en <= i_wb_dat[pilc_pkg::RST_CTL_STICKY_EN];
      end
    end
  end

  // Edge rate and loopback; cable length is a live read-only field
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_ctl2 <= {pilc_pkg::EDGE_RATE_DEFAULT, 13'h0000};
    end else if (i_clk_en) begin
      ext_ctl2[pilc_pkg::CABLE_LEN_HI:pilc_pkg::CABLE_LEN_LO] <= i_cable_len;
      if (soft_rst) begin
        ext_ctl2[pilc_pkg::CONN_LOOPBACK] <= 1'b0;
        if (!sticky_en) begin
          ext_ctl2[pilc_pkg::EDGE_RATE_HI:pilc_pkg::EDGE_RATE_LO] <=
            pilc_pkg::EDGE_RATE_DEFAULT;
        end
      end else if (wr && i_wb_adr == pilc_pkg::IDX_EXT_CTL2) begin
        if (i_wb_sel[1]) begin
          ext_ctl2[pilc_pkg::EDGE_RATE_HI:pilc_pkg::EDGE_RATE_LO] <=
            i_wb_dat[pilc_pkg::EDGE_RATE_HI:pilc_pkg::EDGE_RATE_LO];
        end
        if (i_wb_sel[0]) begin
          ext_ctl2[pilc_pkg::CONN_LOOPBACK] <= i_wb_dat[pilc_pkg::CONN_LOOPBACK];
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= pilc_pkg::IRQ_MASK_DEFAULT;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        irq_mask[pilc_pkg::IRQ_NEG_ERR] <= 1'b0;
        if (!sticky_en) begin
          irq_mask <= pilc_pkg::IRQ_MASK_DEFAULT;
        end
      end else if (wr && i_wb_adr == pilc_pkg::IDX_IRQ_MASK) begin
        irq_mask <= merge(irq_mask, pilc_pkg::IRQ_MASK_WR_BITS, i_wb_dat[15:0],
                          wmask16);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      led_ctl <= pilc_pkg::LED_DEFAULT;
    end else if (i_clk_en) begin
      if (soft_rst && !sticky_en) begin
        led_ctl <= pilc_pkg::LED_DEFAULT;
      end else if (!soft_rst && wr && i_wb_adr == pilc_pkg::IDX_LED_CTL) begin
        led_ctl <= merge(led_ctl, pilc_pkg::LED_WR_BITS, i_wb_dat[15:0], wmask16);
      end
    end
  end

  // Event qualification: speed/duplex need negotiation on, downshift needs all advertise bits
  always_comb begin
    events = 16'h0000;
    events[pilc_pkg::IRQ_SPEED] = i_ev_speed && i_autoneg_en;
    events[pilc_pkg::IRQ_LINK] = i_ev_link;
    events[pilc_pkg::IRQ_DUPLEX] = i_ev_duplex && i_autoneg_en;
    events[pilc_pkg::IRQ_NEG_ERR] = i_ev_neg_err;
    events[pilc_pkg::IRQ_NEG_DONE] = i_ev_neg_done;
    events[pilc_pkg::IRQ_POWERED] = i_ev_powered;
    events[pilc_pkg::IRQ_DOWNSHIFT] = i_ev_downshift && (&i_advert_bits);
    events[pilc_pkg::IRQ_MS_ERR] = i_ev_ms_err;
  end

  // A read clears what it returned; an event in the same cycle survives the clear
  always_comb begin
    next_flags = irq_flags;
    if (rd_flags) begin
      next_flags = 16'h0000;
    end
    next_flags = next_flags | (events & irq_mask & pilc_pkg::IRQ_EVENT_BITS);
    next_flags[pilc_pkg::IRQ_PIN_EN] = |(next_flags & pilc_pkg::IRQ_EVENT_BITS);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_flags <= 16'h0000;
    end else if (i_clk_en) begin
      irq_flags <= next_flags;
    end
  end

  // Pin enable only gates the output, never the latching above
  assign o_management_irq_out = irq_mask[pilc_pkg::IRQ_PIN_EN]
                                && irq_flags[pilc_pkg::IRQ_PIN_EN];
  assign o_negotiation_disabled = !i_autoneg_en;
  assign o_edge_rate = ext_ctl2[pilc_pkg::EDGE_RATE_HI:pilc_pkg::EDGE_RATE_LO];
  assign o_conn_loopback = ext_ctl2[pilc_pkg::CONN_LOOPBACK];

  // Pin inputs: three stages, a change is accepted once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sync_c <= 3'h0;
      link_fast <= 1'b0;
      link_gig <= 1'b0;
      activity <= 1'b0;
    end else if (i_clk_en) begin
      sync_a <= {i_link_fast, i_link_gig, i_activity};
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b[2] == sync_c[2]) link_fast <= sync_c[2];
      if (sync_b[1] == sync_c[1]) link_gig <= sync_c[1];
      if (sync_b[0] == sync_c[0]) activity <= sync_c[0];
    end
  end

  // Pulse and blink timebases run freely so all LEDs share phase
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt <= 14'h0000;
    end else if (i_clk_en) begin
      if (pulse_cnt == 14'(pilc_pkg::PULSE_CYCLES - 1)) pulse_cnt <= 14'h0000;
      else pulse_cnt <= pulse_cnt + 14'h0001;
    end
  end
  assign pulse_on = pulse_cnt < 14'(pilc_pkg::PULSE_ON_CYCLES);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blink_cnt <= 23'h00_0000;
      blink_phase <= 1'b0;
    end else if (i_clk_en) begin
      if (blink_cnt >= (led_ctl[pilc_pkg::LED_RATE] ? 23'(pilc_pkg::BLINK_FAST_HALF - 1)
                                                    : 23'(pilc_pkg::BLINK_SLOW_HALF - 1))) begin
        blink_cnt <= 23'h00_0000;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 23'h00_0001;
      end
    end
  end

  // LED resolution: disable beats force, force beats live state; pulse modulates active LEDs
  function automatic logic led_level(input logic live, input logic force_on, input logic off,
                                     input logic pulse_en, input logic pulse_ph);
    logic lit;
    lit = !off && (force_on || live);
    led_level = lit && (!pulse_en || pulse_ph);
  endfunction

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_activity_light_pin <= 1'b0;
      o_gigabit_link_light_pin <= 1'b0;
      o_fast_link_light_pin <= 1'b0;
    end else if (i_clk_en) begin
      if (i_enhanced_led) begin
        o_fast_link_light_pin <= i_enh_led[2];
        o_gigabit_link_light_pin <= i_enh_led[1];
        o_activity_light_pin <= i_enh_led[0];
      end else begin
        o_fast_link_light_pin <= led_level(link_fast, led_ctl[pilc_pkg::LED_FAST_ON],
          led_ctl[pilc_pkg::LED_FAST_OFF], led_ctl[pilc_pkg::LED_PULSE], pulse_on);
        o_gigabit_link_light_pin <= led_level(link_gig, led_ctl[pilc_pkg::LED_GIG_ON],
          led_ctl[pilc_pkg::LED_GIG_OFF], led_ctl[pilc_pkg::LED_PULSE], pulse_on);
        o_activity_light_pin <= led_level(
          activity && (!led_ctl[pilc_pkg::LED_BLINK] || blink_phase),
          led_ctl[pilc_pkg::LED_ACT_ON], led_ctl[pilc_pkg::LED_ACT_OFF],
          led_ctl[pilc_pkg::LED_PULSE], pulse_on);
      end
    end
  end

  property p_pin_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      !irq_mask[pilc_pkg::IRQ_PIN_EN] |-> !o_management_irq_out;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("irq pin high while disabled");

  property p_pin_follow;
    @(posedge i_clock) disable iff (!i_rst_n)
      irq_mask[pilc_pkg::IRQ_PIN_EN] |-> (o_management_irq_out == (irq_flags != 16'h0000));
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("irq pin not following pending");

  property p_latch;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_ev_link && irq_mask[pilc_pkg::IRQ_LINK]) |=>
        irq_flags[pilc_pkg::IRQ_LINK] && irq_flags[pilc_pkg::IRQ_PIN_EN];
  endproperty
  a_latch: assert property (p_latch) else $error("link event not latched");

  property p_read_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && rd_flags && events == 16'h0000) |=> irq_flags == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

  property p_reserved_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      (irq_flags & ~(pilc_pkg::IRQ_EVENT_BITS | 16'h8000)) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status set");

  property p_speed_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      (!i_autoneg_en && !irq_flags[pilc_pkg::IRQ_SPEED]) |=> !irq_flags[pilc_pkg::IRQ_SPEED];
  endproperty
  a_speed_gate: assert property (p_speed_gate) else $error("speed flag without autoneg");

  property p_down_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_advert_bits != 4'hf && !irq_flags[pilc_pkg::IRQ_DOWNSHIFT])
        |=> !irq_flags[pilc_pkg::IRQ_DOWNSHIFT];
  endproperty
  a_down_gate: assert property (p_down_gate) else $error("downshift flag ungated");

  property p_disable_wins;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && !i_enhanced_led && led_ctl[pilc_pkg::LED_FAST_OFF]) |=> !o_fast_link_light_pin;
  endproperty
  a_disable_wins: assert property (p_disable_wins) else $error("disabled LED lit");

  property p_wb_ack;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && req) |=> o_wb_ack ##1 (!o_wb_ack || !i_clk_en);
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack timing wrong");

  c_irq: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_management_irq_out);
  c_read_clear: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    rd_flags && irq_flags != 16'h0000);
  c_soft_rst: cover property (@(posedge i_clock) disable iff (!i_rst_n) soft_rst && sticky_en);

endmodule // pilc_regs

`default_nettype wire

//--- pkg/pilc_pkg.sv
// Package for the management register slice: offsets, field positions, resets, timing.
// Assumes a 50 MHz core clock and classic Wishbone word addressing by register index.
package pilc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EXT_CTL2 = 8'h18;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h19;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h1a;
  localparam logic [7:0] IDX_LED_CTL = 8'h1b;
  // Own choice: sticky-reset enable and software reset live here
  localparam logic [7:0] IDX_RESET_CTL = 8'h1c;
  localparam int RST_CTL_SWRST = 0;
  localparam int RST_CTL_STICKY_EN = 1;
  localparam logic RST_STICKY_EN_DEFAULT = 1'b1;

  localparam int EDGE_RATE_HI = 15;
  localparam int EDGE_RATE_LO = 13;
  localparam logic [2:0] EDGE_RATE_DEFAULT = 3'h6;
  localparam int CABLE_LEN_HI = 3;
  localparam int CABLE_LEN_LO = 1;
  localparam int CONN_LOOPBACK = 0;

  localparam int IRQ_PIN_EN = 15;
  localparam int IRQ_SPEED = 14;
  localparam int IRQ_LINK = 13;
  localparam int IRQ_DUPLEX = 12;
  localparam int IRQ_NEG_ERR = 11;
  localparam int IRQ_NEG_DONE = 10;
  localparam int IRQ_POWERED = 9;
  localparam int IRQ_DOWNSHIFT = 2;
  localparam int IRQ_MS_ERR = 1;
  localparam logic [15:0] IRQ_EVENT_BITS = 16'h7e06;
  localparam logic [15:0] IRQ_MASK_WR_BITS = 16'hfe06;
  localparam logic [15:0] IRQ_MASK_DEFAULT = 16'h0000;

  localparam int LED_FAST_ON = 13;
  localparam int LED_FAST_OFF = 12;
  localparam int LED_GIG_ON = 11;
  localparam int LED_GIG_OFF = 10;
  localparam int LED_ACT_ON = 7;
  localparam int LED_ACT_OFF = 6;
  localparam int LED_PULSE = 3;
  localparam int LED_BLINK = 2;
  localparam int LED_RATE = 1;
  localparam logic [15:0] LED_WR_BITS = 16'h3cce;
  localparam logic [15:0] LED_DEFAULT = 16'h0000;

  localparam int CLOCK_HZ = 50_000_000;
  localparam int PULSE_HZ = 5_000;
  localparam int PULSE_DUTY_PCT = 20;
  localparam int BLINK_FAST_HZ = 10;
  localparam int BLINK_SLOW_HZ = 5;
  localparam int PULSE_CYCLES = CLOCK_HZ / PULSE_HZ;
  localparam int PULSE_ON_CYCLES = PULSE_CYCLES * PULSE_DUTY_PCT / 100;
  // Half periods: one blink period is an on half and an off half
  localparam int BLINK_FAST_HALF = CLOCK_HZ / (2 * BLINK_FAST_HZ);
  localparam int BLINK_SLOW_HALF = CLOCK_HZ / (2 * BLINK_SLOW_HZ);
endpackage
